// ### dsrm_regs.vh
// Constants for the self-refresh manager.
`ifndef DSRM_REGS_VH
`define DSRM_REGS_VH
`define DSRM_LP_WIDTH        2
`define DSRM_LP_SELF_REFRESH 2'h2
`define DSRM_TIM_WIDTH       4
`define DSRM_TIM_SAFE_MIN    4'h9
`define DSRM_IDLE_SAFE_CYC   4096
`define DSRM_IDLE_BASE_CYC   16'h0010
`define DSRM_REF_MAX         16
`define DSRM_TREFI_NS        7800
`define DSRM_WINDOW_NS       15600
`define DSRM_CLK_PERIOD_NS   40
`define DSRM_CNT_WIDTH       16
`define DSRM_REF_CNT_WIDTH   5
`endif

// ### dsrm_sdram_model.sv
// Behavioural DDR3 device that follows self-refresh and counts refreshes.
`timescale 1ns/1ps
module dsrm_sdram_model #(parameter int WINDOW_CYC = 390) (
    input  wire core_clk_i, reset_i, sr_enter_i, sr_exit_i, refresh_i,
    output reg  asleep_o, fault_o);
    int now, seen;
    int stamp [0:15];
    // A seventeenth refresh inside any sliding window is a fault.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            now = 0;
            seen = 0;
            asleep_o <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            now = now + 1;
            if (refresh_i) begin
                if (seen >= 16 && now - stamp[15] < WINDOW_CYC) fault_o <= 1'b1;
                for (int i = 15; i > 0; i--) stamp[i] = stamp[i-1];
                stamp[0] = now;
                seen = seen + 1;
            end
            if (refresh_i && !(sr_enter_i || sr_exit_i)) fault_o <= 1'b1;
            if ((sr_enter_i && asleep_o) || (sr_exit_i && !asleep_o)) fault_o <= 1'b1;
            if (sr_enter_i || sr_exit_i) asleep_o <= sr_enter_i;
        end
    end
endmodule

// ### dsrm_self_refresh_manager.v
// Self-refresh entry and exit manager of a DDR3 controller.
`timescale 1ns/1ps
`include "dsrm_regs.vh"

module dsrm_self_refresh_manager #(
    parameter IDLE_SAFE_CYC = `DSRM_IDLE_SAFE_CYC,
    parameter WINDOW_CYC    = `DSRM_WINDOW_NS / `DSRM_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire                         core_clk_i,
    input  wire                         reset_i,
    // Configuration
    input  wire [`DSRM_LP_WIDTH-1:0]    low_power_select_i,
    input  wire [`DSRM_TIM_WIDTH-1:0]   self_refresh_idle_timer_i,
    // Command traffic
    input  wire                         cmd_pending_i,
    output reg                          cmd_grant_o,
    // Memory side
    output reg                          sr_enter_o,
    output reg                          sr_exit_o,
    output reg                          refresh_o,
    output reg                          in_self_refresh_o
);

    // One-hot state codes: every state decode compares all four state bits.
    localparam ST_ACTIVE = 4'h1;
    localparam ST_ENTER  = 4'h2;
    localparam ST_SR     = 4'h4;
    localparam ST_EXIT   = 4'h8;

    // Refresh history: ages of the most recent refreshes, newest first.
    localparam CW         = `DSRM_CNT_WIDTH;
    localparam HIST_DEPTH = `DSRM_REF_MAX - 1;
    localparam HIST_W     = HIST_DEPTH * CW;

    reg  [3:0]        state_reg;
    reg  [3:0]        state_next;
    reg  [CW-1:0]     idle_cnt_reg;
    reg  [CW-1:0]     idle_cnt_next;
    reg  [CW-1:0]     idle_limit;
    reg  [HIST_W-1:0] hist_reg;
    wire [HIST_W-1:0] hist_aged;
    wire [HIST_W-1:0] hist_next;
    wire [CW-1:0]     window_len;
    wire [CW-1:0]     oldest_age;
    wire              sr_enabled;
    wire              idle_done;
    wire              ref_room;
    wire              grant_next;
    wire              sleep_next;
    wire              enter_next;
    wire              exit_next;
    wire              refresh_next;

    assign window_len = WINDOW_CYC[CW-1:0];
    assign sr_enabled = (low_power_select_i == `DSRM_LP_SELF_REFRESH);
    assign idle_done  = (idle_cnt_reg >= idle_limit);
    assign oldest_age = hist_reg[HIST_W-1 -: CW];

    // An entry commits two refreshes: its own and the exit that must follow,
    // since an exit is never held back. Entering only while the oldest stored
    // refresh has left the window leaves at most fourteen inside it, so every
    // sliding window, including the one that ends at the later exit, stays
    // within sixteen refreshes.
    assign ref_room   = (oldest_age >= window_len);

    // Shorter codes scale down by powers of two so the map stays monotonic.
    // The largest short code still lands on the safe idle time, never above.
    always @* begin
        if (self_refresh_idle_timer_i >= `DSRM_TIM_SAFE_MIN) begin
            idle_limit = IDLE_SAFE_CYC[CW-1:0];
        end else begin
            idle_limit = `DSRM_IDLE_BASE_CYC << self_refresh_idle_timer_i;
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (sr_enabled && !cmd_pending_i && idle_done && ref_room) begin
                    state_next = ST_ENTER;
                end
            end
            ST_ENTER: begin
                state_next = ST_SR;
            end
            ST_SR: begin
                // Exit is never blocked by the budget: the entry already reserved it.
                if (cmd_pending_i || !sr_enabled) begin
                    state_next = ST_EXIT;
                end
            end
            ST_EXIT: begin
                state_next = ST_ACTIVE;
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end

    // The idle count restarts whenever traffic waits or the memory is not
    // fully awake, and holds once the limit is reached so it cannot wrap.
    always @* begin
        idle_cnt_next = idle_cnt_reg;
        if (state_reg != ST_ACTIVE || cmd_pending_i) begin
            idle_cnt_next = {CW{1'b0}};
        end else if (!idle_done) begin
            idle_cnt_next = idle_cnt_reg + 16'h0001;
        end
    end

    // Every stored age grows by one per cycle and saturates at the window
    // length; a refresh shifts the history and starts a fresh age of zero.
    // Saturation keeps the counters narrow however long the memory sleeps.
    genvar gi;
    generate
        for (gi = 0; gi < HIST_DEPTH; gi = gi + 1) begin : g_hist
            wire [CW-1:0] age_now;
            assign age_now = hist_reg[gi*CW +: CW];
            assign hist_aged[gi*CW +: CW] = (age_now >= window_len) ? age_now
                                                                      : age_now + 16'h0001;
            if (gi == 0) begin : g_head
                assign hist_next[gi*CW +: CW] = refresh_o ? {CW{1'b0}}
                                                          : hist_aged[gi*CW +: CW];
            end else begin : g_tail
                assign hist_next[gi*CW +: CW] = refresh_o ? hist_aged[(gi-1)*CW +: CW]
                                                          : hist_aged[gi*CW +: CW];
            end
        end
    endgenerate

    assign grant_next   = (state_next == ST_ACTIVE) && cmd_pending_i;
    assign sleep_next   = (state_next == ST_SR) || (state_next == ST_ENTER);
    assign enter_next   = (state_reg == ST_ENTER);
    assign exit_next    = (state_reg == ST_EXIT);
    assign refresh_next = enter_next || exit_next;

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            idle_cnt_reg <= {CW{1'b0}};
        end else begin
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // After reset every slot reads as long ago, so the first entries are free.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            hist_reg <= {HIST_DEPTH{WINDOW_CYC[CW-1:0]}};
        end else begin
            hist_reg <= hist_next;
        end
    end

    // Commands may run only while the memory is fully awake.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            cmd_grant_o <= 1'b0;
        end else begin
            cmd_grant_o <= grant_next;
        end
    end

    // Entry command, one cycle after the entry state is reached.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            sr_enter_o <= 1'b0;
        end else begin
            sr_enter_o <= enter_next;
        end
    end

    // Exit command, issued in the same cycle as the grant of the waiting command.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            sr_exit_o <= 1'b0;
        end else begin
            sr_exit_o <= exit_next;
        end
    end

    // Exactly one refresh travels with each entry and each exit.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            refresh_o <= 1'b0;
        end else begin
            refresh_o <= refresh_next;
        end
    end

    // The level rises with the entry decision so no grant slips in behind it.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            in_self_refresh_o <= 1'b0;
        end else begin
            in_self_refresh_o <= sleep_next;
        end
    end

endmodule

// ### dsrm_self_refresh_manager_bench.sv
// Self-checking bench for the self-refresh manager.
`timescale 1ns/1ps
module dsrm_self_refresh_manager_bench;
    reg       clk = 1'b0, rst = 1'b1, pend = 1'b1;
    reg [1:0] lp = 2'h2;
    reg [3:0] tim = 4'h9;
    wire      grant, ent, ext, refr, insr, asleep, fault;
    int       errors = 0, total_checks = 0, cyc = 0, c;
    localparam int WIN = 390;
    always #20 clk = ~clk;
    dsrm_self_refresh_manager #(.IDLE_SAFE_CYC(64), .WINDOW_CYC(WIN)) dut (.core_clk_i(clk),
        .reset_i(rst), .low_power_select_i(lp), .self_refresh_idle_timer_i(tim),
        .cmd_pending_i(pend), .cmd_grant_o(grant), .sr_enter_o(ent), .sr_exit_o(ext),
        .refresh_o(refr), .in_self_refresh_o(insr));
    dsrm_sdram_model #(.WINDOW_CYC(WIN)) mem (.core_clk_i(clk), .reset_i(rst), .sr_enter_i(ent),
        .sr_exit_i(ext), .refresh_i(refr), .asleep_o(asleep), .fault_o(fault));
    task chk(input string n, input logic e, g);
        total_checks++;
        if (g !== e) begin errors++; $display("unexpected %s exp %b got %b", n, e, g); end
    endtask
    task wait_for(input bit g, input int lim);
        c = 0;
        while ((g ? grant : insr) !== 1'b1 && c < lim) begin @(negedge clk); c++; end
    endtask
    task t_sleep(input logic [3:0] code, input int lo, hi);
        @(posedge clk) begin pend <= 1'b0; tim <= code; end
        wait_for(0, hi);
        chk("idle time", 1'b1, c >= lo && c < hi);
        repeat (3) @(negedge clk);
        chk("memory asleep", 1'b1, asleep);
        $display("sleep test done");
    endtask
    task t_wake;
        @(posedge clk) pend <= 1'b1;
        wait_for(1, 20);
        chk("grant", 1'b1, grant);
        repeat (2) @(negedge clk);
        chk("memory awake", 1'b0, asleep);
        $display("wake test done");
    endtask
    // Starts asleep with an empty window: seven quick pairs fit, the eighth waits.
    task t_budget;
        repeat (WIN + 10) @(negedge clk);
        repeat (7) begin t_wake; t_sleep(4'h0, 12, 64); end
        t_wake;
        t_sleep(4'h0, 64, 500);
        chk("refresh budget", 1'b0, fault);
        $display("budget test done");
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin errors++; finish_test; end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_sleep(4'h9, 60, 300);
        t_wake;
        t_sleep(4'h0, 12, 64);
        repeat (3) begin t_wake; t_sleep(4'h1, 28, 64); end
        chk("refresh budget", 1'b0, fault);
        t_budget;
        @(posedge clk) lp <= 2'h0;
        repeat (100) @(negedge clk);
        chk("mode exit", 1'b0, insr);
        chk("mode exit memory", 1'b0, asleep);
        chk("final faults", 1'b0, fault);
        $display("mode test done");
        finish_test;
    end
endmodule

// ### dsrm_sr_assertions.sv
// Port checker for the self-refresh manager, bound to its top module.
`timescale 1ns/1ps
module dsrm_sr_checker #(
    parameter logic [15:0] IDLE_SAFE_CYC = 16'h1000,
    parameter int          WINDOW_CYC    = 390
) (
    input wire       core_clk_i, reset_i, cmd_pending_i, cmd_grant_o, sr_enter_o, sr_exit_o,
    input wire       refresh_o, in_self_refresh_o,
    input wire [1:0] low_power_select_i,
    input wire [3:0] self_refresh_idle_timer_i);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    reg  [15:0] idle_reg;
    int         cyc_cnt;
    int         ref_seen;
    int         ref_time [0:15];
    // Stamps of the last sixteen refreshes, newest first, for the window check.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            cyc_cnt <= 0;
            ref_seen <= 0;
        end else begin
            cyc_cnt <= cyc_cnt + 1;
            if (refresh_o) begin
                ref_seen <= ref_seen + 1;
                ref_time[0] <= cyc_cnt;
                for (int i = 1; i < 16; i++) ref_time[i] <= ref_time[i-1];
            end
        end
    end
    wire [15:0] need = (self_refresh_idle_timer_i >= 4'h9) ? IDLE_SAFE_CYC
                     : (16'h10 << self_refresh_idle_timer_i);
    // Two cycles of slack cover the decision pipeline in front of the state change.
    always @(posedge core_clk_i) begin
        idle_reg <= (reset_i || in_self_refresh_o || cmd_pending_i) ? 16'h0 : idle_reg + 16'h1;
    end
    sequence s_wake; ##[1:4] sr_exit_o; endsequence
    sequence s_fall; $fell(in_self_refresh_o); endsequence
    a_enter_pulse: assert property ($rose(in_self_refresh_o) |=> sr_enter_o && refresh_o)
        else $error("entry without its refresh pulse");
    a_mode_entry: assert property ($rose(in_self_refresh_o) |-> $past(low_power_select_i) == 2'h2)
        else $error("entry outside self-refresh mode");
    a_wake_bound: assert property ($rose(cmd_pending_i) && in_self_refresh_o |-> s_wake)
        else $error("traffic did not wake the memory");
    a_exit_pulse: assert property (s_fall |=> sr_exit_o && refresh_o)
        else $error("exit without its refresh pulse");
    a_grant_awake: assert property (cmd_grant_o |-> !in_self_refresh_o && !sr_enter_o)
        else $error("grant while memory sleeps");
    a_refresh_pair: assert property (refresh_o |-> sr_enter_o || sr_exit_o)
        else $error("refresh outside entry or exit");
    a_idle_wait: assert property ($rose(in_self_refresh_o) |-> idle_reg + 16'h2 >= need)
        else $error("entry before idle time ran out");
    a_refresh_budget: assert property (refresh_o && ref_seen >= 16 |->
            cyc_cnt - ref_time[15] >= WINDOW_CYC)
        else $error("more than sixteen refreshes in one window");
endmodule
bind dsrm_self_refresh_manager dsrm_sr_checker #(.IDLE_SAFE_CYC(IDLE_SAFE_CYC),
    .WINDOW_CYC(WINDOW_CYC)) u_chk (.*);
